// ### rtl/cfrm_defines.vh
// Register offsets, field positions, reset values and timing counts of the fault manager
`ifndef CFRM_DEFINES_VH
`define CFRM_DEFINES_VH
// ==========================================
// Register byte offsets
`define CFRM_CTRL_OFS     8'h00
`define CFRM_RESP_OFS     8'h04
`define CFRM_STATE_OFS    8'h08
`define CFRM_STATUS_OFS   8'h0C
`define CFRM_CLEAR_OFS    8'h10
`define CFRM_ENABLE_OFS   8'h14
`define CFRM_MASK_OFS     8'h18
// ==========================================
// Control fields
`define CFRM_CTRL_RUN_BIT 0
`define CFRM_CTRL_OVSEL_BIT 1
`define CFRM_CTRL_RESET   2'h0
// ==========================================
// Response codes, two bits per source
`define CFRM_RSP_LATCH    2'h0
`define CFRM_RSP_RESTART  2'h1
`define CFRM_RSP_IGNORE   2'h2
`define CFRM_RESP_RESET   12'h000
// Source slots in the response register
`define CFRM_SRC_HSOC     0
`define CFRM_SRC_OV       1
`define CFRM_SRC_UV       2
`define CFRM_SRC_TON      3
`define CFRM_SRC_OT       4
`define CFRM_SRC_WARN     5
// ==========================================
// Status bit positions
`define CFRM_ST_HSOC      0
`define CFRM_ST_OV        1
`define CFRM_ST_UV        2
`define CFRM_ST_TON       3
`define CFRM_ST_OT        4
`define CFRM_ST_BGOT      5
`define CFRM_ST_OCW       6
`define CFRM_ST_OVW       7
`define CFRM_ST_UVW       8
`define CFRM_NSTAT        9
// ==========================================
// Timing
`define CFRM_OC_PWM_COUNTS 2'h3
`define CFRM_RETRY_SOFT_STARTS 3'h7
`endif

// ### rtl/cfrm_pwm_counter.v
// Counts PWM cycle pulses after a trigger and flags completion
`timescale 1ns/1ns
module cfrm_pwm_counter #(
   parameter W = 2
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Control
   input  wire         start_i,
   input  wire         stop_i,
   input  wire         tick_i,
   input  wire [W-1:0] target_i,
   // Result
   output reg          done_o,
   output reg          busy_o
);
   reg [W-1:0] cnt_reg;
   always @(posedge clk_i) begin
      if (rst_i || stop_i) begin
         cnt_reg <= {W{1'b0}};
         busy_o  <= 1'b0;
         done_o  <= 1'b0;
      end else if (start_i && !busy_o) begin
         cnt_reg <= {W{1'b0}};
         busy_o  <= 1'b1;
         done_o  <= 1'b0;
      end else if (busy_o && tick_i) begin
         if (cnt_reg + 1'b1 == target_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end else begin
         done_o <= 1'b0;
      end
   end
endmodule

// ### rtl/cfrm_wb_regs.v
// Classic Wishbone slave holding the fault manager registers
`timescale 1ns/1ns
`include "cfrm_defines.vh"
module cfrm_wb_regs (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // Block side
   input  wire [`CFRM_NSTAT-1:0] event_i,
   input  wire [7:0]  state_i,
   output reg  [1:0]  ctrl_o,
   output reg  [11:0] resp_o,
   output reg  [`CFRM_NSTAT-1:0] status_o,
   output reg  [`CFRM_NSTAT-1:0] enable_o,
   output reg  [`CFRM_NSTAT-1:0] mask_o,
   output reg         run_pulse_o
);
   wire req = cyc_i && stb_i && !ack_o;
   wire wr  = req && we_i && sel_i[0];
   wire [`CFRM_NSTAT-1:0] clr = (wr && adr_i == `CFRM_CLEAR_OFS) ?
                                dat_i[`CFRM_NSTAT-1:0] : {`CFRM_NSTAT{1'b0}};
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o       <= 1'b0;
         dat_o       <= 32'h0;
         ctrl_o      <= `CFRM_CTRL_RESET;
         resp_o      <= `CFRM_RESP_RESET;
         status_o    <= {`CFRM_NSTAT{1'b0}};
         enable_o    <= {`CFRM_NSTAT{1'b0}};
         mask_o      <= {`CFRM_NSTAT{1'b0}};
         run_pulse_o <= 1'b0;
      end else begin
         ack_o       <= req;
         run_pulse_o <= 1'b0;
         // Set wins over clear
         status_o    <= (status_o & ~clr) | event_i;
         if (wr) begin
            case (adr_i)
               `CFRM_CTRL_OFS: begin
                  ctrl_o      <= dat_i[1:0];
                  run_pulse_o <= dat_i[`CFRM_CTRL_RUN_BIT];
               end
               `CFRM_RESP_OFS:   resp_o   <= dat_i[11:0];
               `CFRM_ENABLE_OFS: enable_o <= dat_i[`CFRM_NSTAT-1:0];
               `CFRM_MASK_OFS:   mask_o   <= dat_i[`CFRM_NSTAT-1:0];
               default: ;
            endcase
         end
         if (req && !we_i) begin
            case (adr_i)
               `CFRM_CTRL_OFS:   dat_o <= {30'h0, ctrl_o};
               `CFRM_RESP_OFS:   dat_o <= {20'h0, resp_o};
               `CFRM_STATE_OFS:  dat_o <= {24'h0, state_i};
               `CFRM_STATUS_OFS: dat_o <= {23'h0, status_o};
               `CFRM_ENABLE_OFS: dat_o <= {23'h0, enable_o};
               `CFRM_MASK_OFS:   dat_o <= {23'h0, mask_o};
               default:          dat_o <= 32'h0;
            endcase
         end
      end
   end
endmodule

// ### rtl/cfrm_top.v
// Fault response manager for a synchronous buck converter
`timescale 1ns/1ns
`include "cfrm_defines.vh"
// Operation
// - A high-side overcurrent in latch-off allows three PWM counts, then both FETs off until a run write and power good low.
// - A high-side overcurrent in restart turns both FETs off after three PWM counts, then waits seven soft starts.
// - A high-side overcurrent set to ignore only limits peak current cycle by cycle and keeps power good high.
// - An overvoltage fault turns the high-side off and latches the low-side on in latch-off (one clock only in restart) or holds it until feedback is under 0.2 V.
// - In overvoltage restart, after the low-side action the block waits seven soft starts and restarts.
// - Warnings leave the FETs to the PWM, raise the alert and pull power good low unless ignored.
// - Undervoltage or startup timeout turn both FETs off, then restart after seven soft starts or stay off.
// - Internal overtemperature with restart keeps FETs off until the sensor reports 20 C of cooling.
// - Bandgap overtemperature cannot be ignored and restarts once the die is below threshold.
// - Undervoltage is evaluated only after soft start has completed.
// - Every flagged fault sets its status bit and raises the alert unless masked.
module cfrm_top (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output wire [31:0] dat_o,
   output wire        ack_o,
   // Modulator and power stage
   input  wire        pwm_tick_i,
   input  wire        pwm_high_i,
   input  wire        peak_limit_i,
   input  wire        enable_i,
   input  wire        soft_start_done_i,
   input  wire        soft_start_period_i,
   output reg         hs_gate_o,
   output reg         ls_gate_o,
   output reg         soft_start_go_o,
   // Fault detectors
   input  wire        hs_oc_i,
   input  wire        ov_i,
   input  wire        uv_i,
   input  wire        ton_max_i,
   input  wire        ot_i,
   input  wire        ot_cooled_i,
   input  wire        bg_ot_i,
   input  wire        feedback_low_i,
   input  wire        oc_warn_i,
   input  wire        ov_warn_i,
   input  wire        uv_warn_i,
   // Status outputs
   output reg         power_good_output_o,
   output reg         alert_o,
   output reg         irq_o
);
   // ==========================================
   // States
   localparam ST_RUN    = 3'h0;
   localparam ST_OCWAIT = 3'h1;
   localparam ST_OVHOLD = 3'h2;
   localparam ST_RETRY  = 3'h3;
   localparam ST_COOL   = 3'h4;
   localparam ST_LATCH  = 3'h5;
   localparam ST_IDLE   = 3'h6;

   // Cause codes held beside the state
   localparam [31:0] CAUSE_HSOC = `CFRM_ST_HSOC;
   localparam [31:0] CAUSE_OV   = `CFRM_ST_OV;
   localparam [31:0] CAUSE_UV   = `CFRM_ST_UV;
   localparam [31:0] CAUSE_TON  = `CFRM_ST_TON;
   localparam [31:0] CAUSE_OT   = `CFRM_ST_OT;
   localparam [31:0] CAUSE_BGOT = `CFRM_ST_BGOT;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [2:0] cause_reg;
   reg [2:0] cause_next;
   reg [2:0] retry_reg;
   reg [2:0] retry_next;
   reg       ls_latch_reg;
   reg       ls_latch_next;
   reg       oc_start;

   wire [1:0]  ctrl;
   wire [11:0] resp;
   wire [`CFRM_NSTAT-1:0] status;
   wire [`CFRM_NSTAT-1:0] enable;
   wire [`CFRM_NSTAT-1:0] mask;
   wire        run_pulse;
   wire        oc_done;
   wire        oc_busy;

   // ==========================================
   // Per source response decode
   wire [1:0] rsp_hsoc = resp[2*`CFRM_SRC_HSOC +: 2];
   wire [1:0] rsp_ov   = resp[2*`CFRM_SRC_OV +: 2];
   wire [1:0] rsp_uv   = resp[2*`CFRM_SRC_UV +: 2];
   wire [1:0] rsp_ton  = resp[2*`CFRM_SRC_TON +: 2];
   wire [1:0] rsp_ot   = resp[2*`CFRM_SRC_OT +: 2];
   wire [1:0] rsp_warn = resp[2*`CFRM_SRC_WARN +: 2];

   wire hsoc_act = hs_oc_i && rsp_hsoc != `CFRM_RSP_IGNORE;
   wire ov_act   = ov_i && rsp_ov != `CFRM_RSP_IGNORE;
   wire uv_chk   = uv_i && soft_start_done_i;
   wire uv_act   = uv_chk && rsp_uv != `CFRM_RSP_IGNORE;
   wire ton_act  = ton_max_i && rsp_ton != `CFRM_RSP_IGNORE;
   wire ot_act   = ot_i && rsp_ot != `CFRM_RSP_IGNORE;
   wire restart_en = enable_i || run_pulse;

   // ==========================================
   // Events
   wire [`CFRM_NSTAT-1:0] events = {uv_warn_i, ov_warn_i, oc_warn_i, bg_ot_i, ot_i,
                                    ton_max_i, uv_chk, ov_i, hs_oc_i};

   // ==========================================
   // Register block
   cfrm_wb_regs u_regs (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .cyc_i       (cyc_i),
      .stb_i       (stb_i),
      .we_i        (we_i),
      .adr_i       (adr_i),
      .sel_i       (sel_i),
      .dat_i       (dat_i),
      .dat_o       (dat_o),
      .ack_o       (ack_o),
      .event_i     (events),
      .state_i     ({2'h0, cause_reg, state_reg}),
      .ctrl_o      (ctrl),
      .resp_o      (resp),
      .status_o    (status),
      .enable_o    (enable),
      .mask_o      (mask),
      .run_pulse_o (run_pulse)
   );

   // ==========================================
   // Overcurrent delay of three PWM counts
   // Counter cleared whenever the wait is left, so no stale count survives
   wire oc_stop = state_reg == ST_OCWAIT && state_next != ST_OCWAIT;
   cfrm_pwm_counter #(
      .W (2)
   ) u_oc_cnt (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (oc_start),
      .stop_i   (oc_stop),
      .tick_i   (pwm_tick_i),
      .target_i (`CFRM_OC_PWM_COUNTS),
      .done_o   (oc_done),
      .busy_o   (oc_busy)
   );

   // ==========================================
   // Response state machine
   always @* begin
      state_next    = state_reg;
      cause_next    = cause_reg;
      retry_next    = retry_reg;
      ls_latch_next = ls_latch_reg;
      oc_start      = 1'b0;
      case (state_reg)
         ST_RUN: begin
            if (bg_ot_i) begin
               state_next = ST_COOL;
               cause_next = CAUSE_BGOT[2:0];
            end else if (ot_act) begin
               state_next = (rsp_ot == `CFRM_RSP_RESTART) ? ST_COOL : ST_LATCH;
               cause_next = CAUSE_OT[2:0];
            end else if (ov_act) begin
               state_next    = ST_OVHOLD;
               cause_next    = CAUSE_OV[2:0];
               ls_latch_next = ctrl[`CFRM_CTRL_OVSEL_BIT];
            end else if (uv_act || ton_act) begin
               cause_next = uv_act ? CAUSE_UV[2:0] : CAUSE_TON[2:0];
               retry_next = 3'h0;
               if ((uv_act ? rsp_uv : rsp_ton) == `CFRM_RSP_RESTART)
                  state_next = ST_RETRY;
               else
                  state_next = ST_LATCH;
            end else if (hsoc_act) begin
               state_next = ST_OCWAIT;
               cause_next = CAUSE_HSOC[2:0];
               oc_start   = 1'b1;
            end
         end
         ST_OCWAIT: begin
            if (oc_done) begin
               retry_next = 3'h0;
               state_next = (rsp_hsoc == `CFRM_RSP_RESTART) ? ST_RETRY : ST_LATCH;
            end
         end
         ST_OVHOLD: begin
            if (!ls_latch_reg && feedback_low_i) begin
               retry_next = 3'h0;
               state_next = (rsp_ov == `CFRM_RSP_RESTART) ? ST_RETRY : ST_LATCH;
            end else if (ls_latch_reg && rsp_ov == `CFRM_RSP_RESTART) begin
               retry_next = 3'h0;
               state_next = ST_RETRY;
            end else if (ls_latch_reg && run_pulse) begin
               state_next = ST_IDLE;
            end
         end
         ST_RETRY: begin
            if (soft_start_period_i) begin
               if (retry_reg == `CFRM_RETRY_SOFT_STARTS - 3'h1)
                  state_next = ST_IDLE;
               else
                  retry_next = retry_reg + 3'h1;
            end
         end
         ST_COOL: begin
            if (cause_reg == `CFRM_ST_BGOT ? !bg_ot_i : ot_cooled_i)
               state_next = ST_IDLE;
         end
         ST_LATCH: begin
            if (run_pulse)
               state_next = ST_IDLE;
         end
         ST_IDLE: begin
            if (restart_en)
               state_next = ST_RUN;
         end
         default: state_next = ST_IDLE;
      endcase
      // Bandgap overheat overrides every setting and every state but latch-off
      if (bg_ot_i && state_reg != ST_LATCH) begin
         state_next = ST_COOL;
         cause_next = CAUSE_BGOT[2:0];
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg    <= ST_IDLE;
         cause_reg    <= 3'h0;
         retry_reg    <= 3'h0;
         ls_latch_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cause_reg    <= cause_next;
         retry_reg    <= retry_next;
         ls_latch_reg <= ls_latch_next;
      end
   end

   // ==========================================
   // Gate, power good and alert outputs
   wire running  = state_reg == ST_RUN || state_reg == ST_OCWAIT;
   wire limit    = rsp_hsoc == `CFRM_RSP_IGNORE && peak_limit_i;
   wire warn_any = oc_warn_i || ov_warn_i || uv_warn_i;
   wire warn_pg  = warn_any && rsp_warn != `CFRM_RSP_IGNORE;

   always @(posedge clk_i) begin
      if (rst_i) begin
         hs_gate_o           <= 1'b0;
         ls_gate_o           <= 1'b0;
         soft_start_go_o     <= 1'b0;
         power_good_output_o <= 1'b0;
         alert_o             <= 1'b0;
         irq_o               <= 1'b0;
      end else begin
         hs_gate_o       <= running && pwm_high_i && !limit;
         ls_gate_o       <= (running && !pwm_high_i) || state_reg == ST_OVHOLD;
         soft_start_go_o <= state_reg == ST_IDLE && restart_en;
         power_good_output_o <= running && soft_start_done_i && !warn_pg;
         alert_o         <= |(status & ~mask);
         irq_o           <= |(status & enable);
      end
   end
endmodule

// ### tb/cfrm_top_assertions.sv
// Port checks for the fault response manager
`timescale 1ns/1ns
module cfrm_top_assertions (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Watched ports
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire pwm_high_i,
   input wire bg_ot_i,
   input wire hs_gate_o,
   input wire ls_gate_o,
   input wire power_good_output_o,
   input wire alert_o,
   input wire irq_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========================================
   // Bus handshake
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered");
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   // ==========================================
   // Reset and gates
   chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
      !hs_gate_o && !ls_gate_o && !power_good_output_o && !alert_o && !irq_o)
      else $error("outputs active after reset");
   chk_hs_follows: assert property (hs_gate_o |-> $past(pwm_high_i))
      else $error("high side on without modulator");
   chk_gates_excl: assert property (ls_gate_o |-> !hs_gate_o)
      else $error("both gates on");
   chk_bgot_off: assert property (bg_ot_i ##1 bg_ot_i |=> !hs_gate_o && !ls_gate_o)
      else $error("gates on during bandgap overheat");
   chk_bgot_pg: assert property (bg_ot_i ##1 bg_ot_i |=> !power_good_output_o)
      else $error("power good during bandgap overheat");
   // ==========================================
   // Coverage
   cov_hs_on: cover property ($rose(hs_gate_o));
   cov_ls_only: cover property (ls_gate_o && !hs_gate_o);
   cov_alert: cover property ($rose(alert_o));
   cov_irq: cover property ($rose(irq_o));
endmodule
bind cfrm_top cfrm_top_assertions i_cfrm_top_assertions (.clk_i, .rst_i, .cyc_i, .stb_i,
   .ack_o, .pwm_high_i, .bg_ot_i, .hs_gate_o, .ls_gate_o, .power_good_output_o,
   .alert_o, .irq_o);

// ### tb/cfrm_stage_model.sv
// Modulator and soft-start stand-in for the fault manager bench
`timescale 1ns/1ns
module cfrm_stage_model (
   // Clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // Fault manager side
   input  wire go_i,
   output wire tick_o,
   output wire high_o,
   output wire period_o,
   output reg  done_o
);
   reg [4:0] cnt_reg;
   reg       ramp_reg;
   assign tick_o   = cnt_reg[2:0] == 3'h7;
   assign high_o   = !cnt_reg[2];
   assign period_o = cnt_reg == 5'h1F;
   // ==========================================
   // Ramp completes on the period after go
   always @(posedge clk_i) begin
      cnt_reg <= rst_i ? 5'h00 : cnt_reg + 5'h01;
      if (rst_i || go_i) begin
         ramp_reg <= go_i;
         done_o   <= 1'b0;
      end else if (ramp_reg && period_o) begin
         ramp_reg <= 1'b0;
         done_o   <= 1'b1;
      end
   end
endmodule

// ### tb/cfrm_top_test.sv
// Self-checking bench for the fault response manager
`timescale 1ns/1ns
`include "cfrm_defines.vh"
module cfrm_top_test;
   reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   reg  [7:0]  adr_i = 8'h00;
   reg  [3:0]  sel_i = 4'hF;
   reg  [31:0] dat_i = 32'h0, q, r;
   reg  [8:0]  flt = 9'h000;
   reg         enable_i = 0, feedback_low_i = 0, peak_limit_i = 0, ot_cooled_i = 0;
   wire [31:0] dat_o;
   wire        ack_o, tick, high, done, period, hs_gate_o, ls_gate_o, go;
   wire        pg, alert_o, irq_o;
   int         fail_count = 0, tests_run = 0, s, c, j;
   cfrm_top i_cfrm_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .pwm_tick_i(tick), .pwm_high_i(high), .peak_limit_i,
      .enable_i, .soft_start_done_i(done), .soft_start_period_i(period), .hs_gate_o,
      .ls_gate_o, .soft_start_go_o(go), .hs_oc_i(flt[0]), .ov_i(flt[1]), .uv_i(flt[2]),
      .ton_max_i(flt[3]), .ot_i(flt[4]), .ot_cooled_i, .bg_ot_i(flt[5]),
      .feedback_low_i, .oc_warn_i(flt[6]), .ov_warn_i(flt[7]), .uv_warn_i(flt[8]),
      .power_good_output_o(pg), .alert_o, .irq_o);
   cfrm_stage_model i_cfrm_stage_model (.clk_i, .rst_i, .go_i(go), .tick_o(tick),
      .high_o(high), .period_o(period), .done_o(done));
   // ==========================================
   // Tasks
   task end_of_test;
      if (fail_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task wb(input w, input [7:0] a, input [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         fail_count++;
         end_of_test;
      end
      q = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      wb(1'b1, a, d);
   endtask
   task rd(input [7:0] a, input [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task st(input [2:0] e);
      wb(1'b0, `CFRM_STATE_OFS, 32'h0);
      chk(q & 32'h7, {29'h0, e});
   endtask
   task hit(input int b, input int n);
      @(posedge clk_i);
      flt[b] <= 1'b1;
      idle(n);
      flt[b] <= 1'b0;
   endtask
   function [2:0] exp_state(input [1:0] code);
      exp_state = code == `CFRM_RSP_LATCH ? 3'h5 : code == `CFRM_RSP_RESTART ? 3'h3 : 3'h0;
   endfunction
   // ==========================================
   // Stimulus
   initial forever #2 clk_i = ~clk_i;
   initial begin
      idle(100000);
      fail_count++;
      end_of_test;
   end
   initial begin
      c = $urandom(83602);
      idle(8);
      rst_i <= 1'b0;
      rd(`CFRM_RESP_OFS, 32'h0);
      rd(`CFRM_STATUS_OFS, 32'h0);
      rd(`CFRM_ENABLE_OFS, 32'h0);
      rd(`CFRM_MASK_OFS, 32'h0);
      rd(8'h1C, 32'h0);
      st(3'h6);
      enable_i <= 1'b1;
      hit(2, 4);
      rd(`CFRM_STATUS_OFS, 32'h0);
      idle(100);
      st(3'h0);
      for (c = 0; c < 4; c++) begin
         r = 0;
         for (j = 0; j < 6; j++)
            r = r | (($urandom % 3) << (2 * j));
         wr(`CFRM_RESP_OFS, r);
         rd(`CFRM_RESP_OFS, r);
         r = $urandom;
         wr(`CFRM_MASK_OFS, r);
         rd(`CFRM_MASK_OFS, r & 32'h1FF);
      end
      wr(`CFRM_MASK_OFS, 32'h0);
      wr(`CFRM_RESP_OFS, 32'hAAA);
      for (s = 0; s < `CFRM_NSTAT; s++) begin
         wr(`CFRM_CLEAR_OFS, 32'h1FF);
         hit(s, 24);
         rd(`CFRM_STATUS_OFS, 32'h1 << s);
         idle(s == 5 ? 400 : 4);
      end
      wr(`CFRM_CLEAR_OFS, 32'h1FF);
      rd(`CFRM_STATUS_OFS, 32'h0);
      wr(`CFRM_RESP_OFS, 32'h0);
      wr(`CFRM_ENABLE_OFS, 32'h40);
      flt[6] <= 1'b1;
      idle(8);
      chk(pg, 1'b0);
      chk({irq_o, alert_o}, 2'b11);
      st(3'h0);
      flt[6] <= 1'b0;
      wr(`CFRM_ENABLE_OFS, 32'h0);
      idle(1);
      chk(irq_o, 1'b0);
      wr(`CFRM_CLEAR_OFS, 32'h40);
      wr(`CFRM_MASK_OFS, 32'h40);
      hit(6, 8);
      idle(2);
      chk(alert_o, 1'b0);
      rd(`CFRM_STATUS_OFS, 32'h40);
      wr(`CFRM_MASK_OFS, 32'h0);
      wr(`CFRM_CLEAR_OFS, 32'h1FF);
      for (s = 0; s < 3; s = s + 2)
         for (c = 0; c < 3; c++) begin
            wr(`CFRM_RESP_OFS, c << (2 * s));
            hit(s, 48);
            st(exp_state(c));
            chk({pg, hs_gate_o | ls_gate_o}, c == 2 ? 2'b11 : 2'b00);
            if (c == 0) begin
               idle(300);
               st(3'h5);
               wr(`CFRM_CTRL_OFS, 32'h1);
            end
            idle(400);
            st(3'h0);
         end
      wr(`CFRM_RESP_OFS, 32'h2);
      peak_limit_i <= 1'b1;
      idle(4);
      chk({pg, hs_gate_o}, 2'b10);
      peak_limit_i <= 1'b0;
      wr(`CFRM_CTRL_OFS, 32'h2);
      wr(`CFRM_RESP_OFS, 32'h0);
      hit(1, 24);
      chk({hs_gate_o, ls_gate_o}, 2'b01);
      wr(`CFRM_CTRL_OFS, 32'h3);
      idle(400);
      st(3'h0);
      wr(`CFRM_CTRL_OFS, 32'h0);
      wr(`CFRM_RESP_OFS, 32'h4);
      hit(1, 24);
      chk({hs_gate_o, ls_gate_o}, 2'b01);
      feedback_low_i <= 1'b1;
      idle(4);
      chk(ls_gate_o, 1'b0);
      st(3'h3);
      feedback_low_i <= 1'b0;
      idle(400);
      st(3'h0);
      wr(`CFRM_RESP_OFS, 32'h100);
      hit(4, 8);
      st(3'h4);
      chk({pg, hs_gate_o, ls_gate_o}, 3'h0);
      ot_cooled_i <= 1'b1;
      idle(4);
      ot_cooled_i <= 1'b0;
      st(3'h0);
      end_of_test;
   end
endmodule
